// ==== fb_pkg.sv ====
// shared constants and types for the fieldbus port interface
package fb_pkg;

  // ==========================================================
  // sizes and clock
  localparam int NUM_PORTS = 4;
  localparam int CLK_MHZ = 200;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PHYADDR = 8'h04;
  localparam logic [7:0] REG_MDIO_CMD = 8'h08;
  localparam logic [7:0] REG_MDIO_STAT = 8'h0C;
  localparam logic [7:0] REG_LINK = 8'h10;
  localparam logic [7:0] REG_RXERR = 8'h14;

  // control register fields
  localparam int CTRL_FWD_EN = 0;
  localparam int CTRL_LINK_POL = 1;
  localparam int CTRL_OFS_LSB = 2;
  localparam int CTRL_INDIV = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] PHYADDR_RESET = 32'h0302_0100;

  // command register fields
  localparam int CMD_REG_LSB = 0;
  localparam int CMD_PORT_LSB = 5;
  localparam int CMD_READ = 7;
  localparam int CMD_DATA_LSB = 16;
  localparam int STAT_DATA_LSB = 16;

  // address offset selections
  localparam logic [1:0] OFS_NONE = 2'h0;
  localparam logic [1:0] OFS_ONE = 2'h1;
  localparam logic [1:0] OFS_SIXTEEN = 2'h2;
  localparam logic [4:0] ADDR_OFS_ONE = 5'h01;
  localparam logic [4:0] ADDR_OFS_SIXTEEN = 5'h10;

  // ==========================================================
  // management frame timing and layout
  localparam int MDC_HALF_NS = 200;
  localparam logic [5:0] MDC_HALF_CYC =
    6'((MDC_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [5:0] MDIO_LAST_BIT = 6'h3F;
  localparam logic [5:0] MDIO_TA_BIT = 6'h2E;
  localparam logic [5:0] MDIO_DATA_BIT = 6'h30;
  localparam logic [31:0] MDIO_PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0] MDIO_ST = 2'h1;
  localparam logic [1:0] MDIO_OP_WR = 2'h1;
  localparam logic [1:0] MDIO_OP_RD = 2'h2;
  localparam logic [1:0] MDIO_TA_WR = 2'h2;

  // ==========================================================
  // types
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } fb_mii_rx_t;

  typedef struct packed {
    logic en;
    logic [3:0] d;
  } fb_mii_tx_t;

  typedef enum logic [1:0] {
    MD_IDLE = 2'b00,
    MD_LOW = 2'b01,
    MD_HIGH = 2'b10
  } fb_md_state_t;

endpackage

// ==== fb_port_rx.sv ====
// per-port receive sampler: pin synchronisers, clock edge, link polarity
`timescale 1ns/1ps
`default_nettype none
module fb_port_rx
  import fb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // pins from the transceiver
  input wire logic rx_clk_pin,
  input wire logic link_pin,
  input wire fb_mii_rx_t rx_pin,
  // configuration
  input wire logic link_pol,
  // sampled results
  output logic link_up,
  output logic nib_valid,
  output fb_mii_rx_t nib
);

  logic [2:0] clk_s_reg, clk_s_next;
  logic [2:0] lnk_s_reg, lnk_s_next;
  fb_mii_rx_t [2:0] dat_s_reg, dat_s_next;
  logic clk_lvl_reg, clk_lvl_next;
  logic lnk_lvl_reg, lnk_lvl_next;
  logic link_up_reg, link_up_next;
  logic nib_valid_reg, nib_valid_next;
  fb_mii_rx_t nib_reg, nib_next;

  // three-stage sync; a level is accepted only once stages two and three
  // agree, so stage one never feeds any decision
  always_comb
  begin
    clk_s_next = {clk_s_reg[1:0], rx_clk_pin};
    lnk_s_next = {lnk_s_reg[1:0], link_pin};
    dat_s_next = {dat_s_reg[1:0], rx_pin};
    clk_lvl_next = clk_lvl_reg;
    lnk_lvl_next = lnk_lvl_reg;
    nib_valid_next = 1'b0;
    nib_next = nib_reg;
    if (clk_s_reg[1] == clk_s_reg[2])
    begin
      clk_lvl_next = clk_s_reg[2];
      // rising edge of the receive clock: data is taken from the same depth
      if (clk_s_reg[2] && !clk_lvl_reg)
      begin
        nib_valid_next = 1'b1;
        nib_next = dat_s_reg[2];
      end
    end
    if (lnk_s_reg[1] == lnk_s_reg[2])
      lnk_lvl_next = lnk_s_reg[2];
    // polarity 0 means the pin is active low
    link_up_next = link_pol ? lnk_lvl_reg : !lnk_lvl_reg; // R11
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_s_reg <= 3'h0;
      lnk_s_reg <= 3'h7;
      dat_s_reg <= '0;
      clk_lvl_reg <= 1'b0;
      lnk_lvl_reg <= 1'b1;
      link_up_reg <= 1'b0;
      nib_valid_reg <= 1'b0;
      nib_reg <= '0;
    end
    else if (ce)
    begin
      clk_s_reg <= clk_s_next;
      lnk_s_reg <= lnk_s_next;
      dat_s_reg <= dat_s_next;
      clk_lvl_reg <= clk_lvl_next;
      lnk_lvl_reg <= lnk_lvl_next;
      link_up_reg <= link_up_next;
      nib_valid_reg <= nib_valid_next;
      nib_reg <= nib_next;
    end
  end

  assign link_up = link_up_reg;
  assign nib_valid = nib_valid_reg;
  assign nib = nib_reg;

  // link state follows the agreed level with the polarity of the cycle
  // before, since both feed the same register stage
  link_pol_a: assert property (@(posedge sys_clk) disable iff (rst || !ce)
    ##1 ce |-> link_up_reg == ($past(link_pol) ? $past(lnk_lvl_reg)
                                              : !$past(lnk_lvl_reg)))
    else $error("link state does not follow link pin polarity"); // R11

endmodule
`default_nettype wire

// ==== fb_port_if.sv ====
// port interface top: cut-through forwarding, link gating, management master
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: nibbles are forwarded to the next port as soon as they arrive.
// R2: ports run 100 Mbit/s full duplex, one nibble per receive clock.
// R3: transceivers support 100 Mbit/s full-duplex links.
// R4: transceivers offer a media-independent interface to this block.
// R5: transceivers autonegotiate in twisted-pair mode.
// R6: transceivers implement the serial management interface.
// R7: transceivers keep the preamble length unchanged.
// R8: transceivers never use energy-efficient idle on these links.
// R9: transceivers flag every invalid symbol with receive-error, anywhere.
// R10: a trailing odd nibble arrives without a receive-error mark.
// R11: link input is active low by default, polarity selectable.
// R12: one shared management bus reaches up to four transceivers.
// R13: transceivers use addresses 0 to 3, none as broadcast.
// R14: individual per-port addresses may replace consecutive ones.
// R15: fixed base offset of 16 or 1 may be applied.
// R16: transceivers work after power-on without management writes.
// R17: software may configure transceivers over management, e.g. advertisement.
// R18: link input is inactive without a link, never an activity signal.
// R19: transceiver start-up never waits for management clock activity.
// R20: management address is base offset plus port unless individual.
// R21: forwarding only while both ports report link after polarity.
module fb_port_if
  import fb_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // transceiver data pins
  input wire logic [NUM_PORTS-1:0] rx_clk_pin,
  input wire logic [NUM_PORTS-1:0] link_pin,
  input wire fb_mii_rx_t [NUM_PORTS-1:0] mii_rx,
  output fb_mii_tx_t [NUM_PORTS-1:0] mii_tx,
  // shared management bus
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe
);

  // ==========================================================
  // per-port receive samplers
  logic [NUM_PORTS-1:0] link_up, nib_valid;
  fb_mii_rx_t [NUM_PORTS-1:0] nib;
  logic [31:0] ctrl_reg, ctrl_next;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_port
      fb_port_rx u_rx (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .rx_clk_pin(rx_clk_pin[g]),
        .link_pin(link_pin[g]),
        .rx_pin(mii_rx[g]),
        .link_pol(ctrl_reg[CTRL_LINK_POL]),
        .link_up(link_up[g]),
        .nib_valid(nib_valid[g]),
        .nib(nib[g])
      );
    end
  endgenerate

  // ==========================================================
  // forwarding: port j transmits what port j-1 receives, no store
  fb_mii_tx_t [NUM_PORTS-1:0] tx_reg, tx_next;
  logic [NUM_PORTS-1:0] rxerr_reg, rxerr_next;

  always_comb
  begin
    int s;
    s = 0;
    tx_next = tx_reg;
    for (int j = 0; j < NUM_PORTS; j++)
    begin
      s = (j == 0) ? NUM_PORTS - 1 : j - 1;
      // a half-open link must not carry frames in either direction
      if (!(ctrl_reg[CTRL_FWD_EN] && link_up[s] && link_up[j])) // R21
        tx_next[j].en = 1'b0;
      else if (nib_valid[s]) // R1
      begin
        tx_next[j].en = nib[s].dv; // R2
        tx_next[j].d = nib[s].d;
      end
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait states, always okay
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [31:0] phyaddr_reg, phyaddr_next;
  logic addr_ph;

  // management engine state
  fb_md_state_t md_state_reg, md_state_next;
  logic [63:0] md_shift_reg, md_shift_next;
  logic [5:0] md_bit_reg, md_bit_next;
  logic [5:0] md_div_reg, md_div_next;
  logic md_rd_reg, md_rd_next;
  logic [15:0] md_rdata_reg, md_rdata_next;
  logic mdc_reg, mdc_next;
  logic mdio_o_reg, mdio_o_next;
  logic mdio_oe_reg, mdio_oe_next;
  logic [2:0] md_s_reg;
  logic md_lvl_reg;
  logic md_start;
  logic [4:0] md_base, md_phy;
  logic [1:0] cmd_port;

  assign addr_ph = hsel && htrans[1] && hready;
  assign cmd_port = hwdata[CMD_PORT_LSB +: 2];

  // address: base offset plus port, or the port's own field
  always_comb
  begin
    case (ctrl_reg[CTRL_OFS_LSB +: 2])
      OFS_ONE: md_base = ADDR_OFS_ONE; // R15
      OFS_SIXTEEN: md_base = ADDR_OFS_SIXTEEN; // R15
      default: md_base = 5'h00;
    endcase
    if (ctrl_reg[CTRL_INDIV])
      md_phy = phyaddr_reg[{cmd_port, 3'h0} +: 5]; // R14
    else
      md_phy = md_base + {3'h0, cmd_port}; // R20
  end

  // commands written while a frame runs are dropped, not queued
  assign md_start = wr_pend_reg && (wr_addr_reg == REG_MDIO_CMD)
                    && (md_state_reg == MD_IDLE);

  // register writes in the data phase, read data prepared in address phase
  always_comb
  begin
    wr_pend_next = addr_ph && hwrite;
    wr_addr_next = haddr[7:0];
    ctrl_next = ctrl_reg;
    phyaddr_next = phyaddr_reg;
    hrdata_next = 32'h0000_0000;
    // hardware sets win over a software clear in the same cycle
    rxerr_next = rxerr_reg;
    if (wr_pend_reg && wr_addr_reg == REG_CTRL)
      ctrl_next = hwdata;
    if (wr_pend_reg && wr_addr_reg == REG_PHYADDR)
      phyaddr_next = hwdata;
    if (wr_pend_reg && wr_addr_reg == REG_RXERR)
      rxerr_next = rxerr_reg & ~hwdata[NUM_PORTS-1:0];
    for (int k = 0; k < NUM_PORTS; k++)
      if (nib_valid[k] && nib[k].er)
        rxerr_next[k] = 1'b1;
    if (addr_ph && !hwrite)
    begin
      case (haddr[7:0])
        REG_CTRL: hrdata_next = {27'h000_0000, ctrl_reg[4:0]};
        REG_PHYADDR: hrdata_next = phyaddr_reg & 32'h1F1F_1F1F;
        REG_MDIO_STAT: hrdata_next = {md_rdata_reg, 15'h0000,
                                      md_state_reg != MD_IDLE};
        REG_LINK: hrdata_next = {28'h000_0000, link_up};
        REG_RXERR: hrdata_next = {28'h000_0000, rxerr_reg};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // management master: mdc only toggles while a frame runs
  always_comb
  begin
    md_state_next = md_state_reg;
    md_shift_next = md_shift_reg;
    md_bit_next = md_bit_reg;
    md_div_next = md_div_reg + 6'h01;
    md_rd_next = md_rd_reg;
    md_rdata_next = md_rdata_reg;
    mdc_next = mdc_reg;
    mdio_o_next = mdio_o_reg;
    mdio_oe_next = mdio_oe_reg;
    case (md_state_reg)
      MD_IDLE:
      begin
        md_div_next = 6'h00;
        mdc_next = 1'b0;
        mdio_oe_next = 1'b0;
        mdio_o_next = 1'b1;
        if (md_start) // R12
        begin
          md_rd_next = hwdata[CMD_READ];
          md_bit_next = 6'h00;
          md_shift_next = {MDIO_PREAMBLE, MDIO_ST,
                           hwdata[CMD_READ] ? MDIO_OP_RD : MDIO_OP_WR,
                           md_phy, hwdata[CMD_REG_LSB +: 5],
                           hwdata[CMD_READ] ? 2'h0 : MDIO_TA_WR,
                           hwdata[CMD_DATA_LSB +: 16]}; // R17
          md_state_next = MD_LOW;
          mdio_oe_next = 1'b1;
          mdio_o_next = 1'b1;
        end
      end
      MD_LOW:
      begin
        // drive the bit; a read releases the line from turnaround onward
        mdio_o_next = md_shift_reg[63];
        mdio_oe_next = !(md_rd_reg && md_bit_reg >= MDIO_TA_BIT); // R12
        if (md_div_reg == MDC_HALF_CYC - 6'h01)
        begin
          md_div_next = 6'h00;
          mdc_next = 1'b1;
          md_state_next = MD_HIGH;
          if (md_rd_reg && md_bit_reg >= MDIO_DATA_BIT)
            md_rdata_next = {md_rdata_reg[14:0], md_lvl_reg};
        end
      end
      MD_HIGH:
      begin
        if (md_div_reg == MDC_HALF_CYC - 6'h01)
        begin
          md_div_next = 6'h00;
          mdc_next = 1'b0;
          md_shift_next = {md_shift_reg[62:0], 1'b1};
          md_bit_next = md_bit_reg + 6'h01;
          md_state_next = MD_LOW;
          if (md_bit_reg == MDIO_LAST_BIT)
          begin
            md_state_next = MD_IDLE;
            mdio_oe_next = 1'b0;
          end
        end
      end
      default: md_state_next = MD_IDLE;
    endcase
  end

  // ==========================================================
  // all state registers; the clock enable freezes everything
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_reg <= '0;
      rxerr_reg <= '0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
      phyaddr_reg <= PHYADDR_RESET;
      md_state_reg <= MD_IDLE;
      md_shift_reg <= 64'h0000_0000_0000_0000;
      md_bit_reg <= 6'h00;
      md_div_reg <= 6'h00;
      md_rd_reg <= 1'b0;
      md_rdata_reg <= 16'h0000;
      mdc_reg <= 1'b0;
      mdio_o_reg <= 1'b1;
      mdio_oe_reg <= 1'b0;
      md_s_reg <= 3'h7;
      md_lvl_reg <= 1'b1;
    end
    else if (ce)
    begin
      tx_reg <= tx_next;
      rxerr_reg <= rxerr_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      ctrl_reg <= ctrl_next;
      phyaddr_reg <= phyaddr_next;
      md_state_reg <= md_state_next;
      md_shift_reg <= md_shift_next;
      md_bit_reg <= md_bit_next;
      md_div_reg <= md_div_next;
      md_rd_reg <= md_rd_next;
      md_rdata_reg <= md_rdata_next;
      mdc_reg <= mdc_next;
      mdio_o_reg <= mdio_o_next;
      mdio_oe_reg <= mdio_oe_next;
      // management input sync; stage one feeds only stage two
      md_s_reg <= {md_s_reg[1:0], mdio_i};
      if (md_s_reg[1] == md_s_reg[2])
        md_lvl_reg <= md_s_reg[2];
    end
  end

  assign mii_tx = tx_reg;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mdc = mdc_reg;
  assign mdio_o = mdio_o_reg;
  assign mdio_oe = mdio_oe_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);

  fwd_gate_a: assert property (tx_reg[0].en |-> $past(link_up[0])
      && $past(link_up[NUM_PORTS-1]) && $past(ctrl_reg[CTRL_FWD_EN])) // R21
    else $error("transmit active without link on both ports");
  fwd_next_a: assert property (nib_valid[NUM_PORTS-1] && link_up[0]
      && link_up[NUM_PORTS-1] && ctrl_reg[CTRL_FWD_EN]
      |=> tx_reg[0].d == $past(nib[NUM_PORTS-1].d)) // R1
    else $error("received nibble not forwarded in the next cycle");
  tx_rate_a: assert property ($changed(tx_reg[0].d)
      |-> $past(nib_valid[NUM_PORTS-1])) // R2
    else $error("transmit data changed without a received nibble");
  addr_off16_a: assert property (md_start && !ctrl_reg[CTRL_INDIV]
      && ctrl_reg[CTRL_OFS_LSB +: 2] == OFS_SIXTEEN
      |-> md_phy == 5'h10 + {3'h0, cmd_port}) // R15
    else $error("offset sixteen address wrong");
  addr_off1_a: assert property (md_start && !ctrl_reg[CTRL_INDIV]
      && ctrl_reg[CTRL_OFS_LSB +: 2] == OFS_ONE
      |=> md_shift_reg[27:23] == $past(5'h01 + {3'h0, cmd_port})) // R20
    else $error("offset one address not loaded into frame");
  addr_indiv_a: assert property (md_start && ctrl_reg[CTRL_INDIV]
      |-> md_phy == phyaddr_reg[{cmd_port, 3'h0} +: 5]) // R14
    else $error("individual address not used");
  mdc_idle_a: assert property (md_state_reg == MD_IDLE
      ##1 md_state_reg == MD_IDLE |-> !mdc_reg && !mdio_oe_reg) // R12
    else $error("management bus active while idle");
  start_busy_a: assert property (md_start |=> md_state_reg == MD_LOW
      ##[39:40] mdc_reg) // R12
    else $error("management frame did not start on time");
  rd_release_a: assert property (md_state_reg == MD_LOW && md_rd_reg
      && md_bit_reg >= MDIO_TA_BIT |=> !mdio_oe_reg) // R12
    else $error("read frame still drives during turnaround");
  wr_drive_a: assert property (md_state_reg != MD_IDLE && !md_rd_reg
      |=> mdio_oe_reg || $past(md_bit_reg) == MDIO_LAST_BIT) // R17
    else $error("write frame released the data line");

  fwd_c: cover property (tx_reg[0].en ##1 !tx_reg[0].en);
  rd_c: cover property (md_start && hwdata[CMD_READ]);
  wr_c: cover property (md_start && !hwdata[CMD_READ]);
  rxerr_c: cover property ($rose(rxerr_reg[0]));

endmodule
`default_nettype wire

// ==== fb_phy_model.sv ====
// transceiver model for all four ports: receive pins, link, management
`timescale 1ns/1ps
`default_nettype none
module fb_phy_model
  import fb_pkg::*;
#(
  parameter logic [15:0] RD_VAL = 16'h5A3C
)
(
  // pins toward the block
  output logic [NUM_PORTS-1:0] rx_clk_pin,
  output logic [NUM_PORTS-1:0] link_pin,
  output fb_mii_rx_t [NUM_PORTS-1:0] mii_rx,
  // shared management bus, line already resolved by the bench
  input wire logic mdc,
  input wire logic mdio,
  output logic phy_oe,
  output logic phy_o
);
  logic [63:0] sr;
  logic [6:0] cnt;
  logic [1:0] op;
  logic [4:0] addr;
  logic [4:0] rnum;
  logic [15:0] wdat;
  int frames;

  // ==========================================================
  // link and receive side
  // links up from power-on, full duplex, no setup writes needed
  initial
  begin
    rx_clk_pin = '0;
    link_pin = '0;
    mii_rx = '0;
    phy_oe = 1'b0;
    phy_o = 1'b1;
    cnt = '0;
    op = '0;
    frames = 0;
  end

  // link pin is a true link flag, inactive without a link
  task automatic set_link(input int p, input logic up);
    link_pin[p] = ~up;
  endtask

  // one nibble per clock, then one idle beat; clock stands still after it
  task automatic send(input int p, input int n, input logic [3:0] b,
                      input int er_at);
    for (int i = 0; i < n; i++)
    begin
      mii_rx[p] = '{dv: 1'b1, er: (i == er_at), d: b + 4'(i)};
      #24 rx_clk_pin[p] = 1'b1;
      #24 rx_clk_pin[p] = 1'b0;
    end
    // released data shows the inverse so stale values cannot pass
    mii_rx[p] = '{dv: 1'b0, er: 1'b0, d: ~mii_rx[p].d};
    // the block only sees valid drop on a receive clock edge
    #24 rx_clk_pin[p] = 1'b1;
    #24 rx_clk_pin[p] = 1'b0;
  endtask

  // ==========================================================
  // management responder
  // bits taken on rising mdc; start-up never waits for mdc
  always @(posedge mdc)
  begin
    sr = {sr[62:0], mdio};
    cnt = cnt + 7'd1;
    if (cnt == 7'd36)
      op = sr[1:0];
    if (cnt == 7'd46)
      {addr, rnum} = sr[9:0];
    if (cnt == 7'd64)
    begin
      wdat = sr[15:0];
      frames++;
      cnt = '0;
    end
  end

  // read data driven on falling mdc, line released after the frame
  always @(negedge mdc)
  begin
    phy_oe = (op == MDIO_OP_RD) && cnt >= 7'd47 && cnt <= 7'd63;
    phy_o = (cnt == 7'd47) ? 1'b0 : RD_VAL[4'(63 - cnt)];
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the port interface block
`timescale 1ns/1ps
`default_nettype none
module tb
  import fb_pkg::*;
;
  localparam logic [15:0] PHY_RD = 16'h5A3C;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [1:0] port;
    logic [4:0] rnum;
    logic [15:0] data;
    logic [4:0] addr;
  } fb_row_t;
  // addressing modes: none, offset 16, offset 1, individual, code 3
  localparam fb_row_t ROWS [5] = '{
    '{32'h0000_0001, 2'h2, 5'h05, 16'hA5A5, 5'h02},
    '{32'h0000_0009, 2'h3, 5'h1F, 16'h8001, 5'h13},
    '{32'h0000_0005, 2'h3, 5'h00, 16'h0F0F, 5'h04},
    '{32'h0000_0011, 2'h1, 5'h04, 16'h1234, 5'h07},
    '{32'h0000_000D, 2'h1, 5'h09, 16'hFFFF, 5'h01}};
  logic sys_clk;
  logic rst;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout, hresp, mdc, mdio_o, mdio_oe, phy_oe, phy_o;
  logic [NUM_PORTS-1:0] rx_clk_pin, link_pin;
  fb_mii_rx_t [NUM_PORTS-1:0] mii_rx;
  fb_mii_tx_t [NUM_PORTS-1:0] mii_tx;
  wire logic mdio_line;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  logic [31:0] rd;

  // ==========================================================
  // wiring
  // management line has a pull-up, so released reads high
  assign mdio_line = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);

  fb_port_if dut_u (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .hsel(htrans[1]),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_clk_pin(rx_clk_pin),
    .link_pin(link_pin), .mii_rx(mii_rx), .mii_tx(mii_tx), .mdc(mdc),
    .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe));

  fb_phy_model #(.RD_VAL(PHY_RD)) phy_u (
    .rx_clk_pin(rx_clk_pin), .link_pin(link_pin), .mii_rx(mii_rx),
    .mdc(mdc), .mdio(mdio_line), .phy_oe(phy_oe), .phy_o(phy_o));

  // clock and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #400_000;
    error_cnt++;
    end_of_test();
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one single word transfer; either phase may be stretched
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge sys_clk);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // poll busy with a bound longer than one frame
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h0000_0001;
    for (int i = 0; i < 4000 && s[0] !== 1'b0; i++)
      ahb(1'b0, REG_MDIO_STAT, 32'h0000_0000, s);
    check({31'h0, s[0]}, 32'h0000_0000);
  endtask

  // frame on port p, watched at the next port 41 ns after each receive clock rise
  task automatic fwd(input int p, input int k, input logic en);
    logic [3:0] b;
    b = 4'(p + 3);
    fork
      phy_u.send(p, k, b, -1);
      for (int i = 0; i < k; i++)
      begin
        @(posedge rx_clk_pin[p]);
        #41;
        check({27'h0, mii_tx[(p + 1) % 4] & {1'b1, {4{en}}}},
              {27'h0, en, (b + 4'(i)) & {4{en}}});
      end
    join
    #100;
    check({31'h0, mii_tx[(p + 1) % 4].en}, 32'h0000_0000);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    htrans = 2'h0;
    haddr = '0;
    hwrite = 1'b0;
    hwdata = '0;
    repeat (3) @(posedge sys_clk);
    check({27'h0, mdc, mdio_o, mdio_oe, hreadyout, hresp},
          32'h0000_000A);
    check(hrdata | 32'(mii_tx), 32'h0000_0000);
    rst <= 1'b0;
    ahb(1'b0, REG_CTRL, 32'h0, rd);
    check(rd, CTRL_RESET);
    ahb(1'b0, REG_PHYADDR, 32'h0, rd);
    check(rd, PHYADDR_RESET);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0000_0000);
    ahb(1'b1, REG_PHYADDR, 32'h1D0A_0713, rd);
    ahb(1'b0, REG_PHYADDR, 32'h0, rd);
    check(rd, 32'h1D0A_0713);
    // each addressing mode sends one write frame
    foreach (ROWS[i])
    begin
      ahb(1'b1, REG_CTRL, ROWS[i].ctrl, rd);
      n = phy_u.frames;
      ahb(1'b1, REG_MDIO_CMD, {ROWS[i].data, 9'h000, ROWS[i].port,
          ROWS[i].rnum}, rd);
      wait_idle();
      check(32'(phy_u.frames - n), 32'h0000_0001);
      check({phy_u.wdat, 1'b0, phy_u.op, phy_u.rnum, 3'h0, phy_u.addr},
            {ROWS[i].data, 1'b0, MDIO_OP_WR, ROWS[i].rnum, 3'h0,
             ROWS[i].addr});
    end
    // read frame, with a second command refused while busy
    ahb(1'b1, REG_CTRL, 32'h0000_0001, rd);
    n = phy_u.frames;
    ahb(1'b1, REG_MDIO_CMD, 32'h0000_0082, rd);
    ahb(1'b1, REG_MDIO_CMD, 32'h7777_0023, rd);
    wait_idle();
    ahb(1'b0, REG_MDIO_STAT, 32'h0, rd);
    check(rd, {PHY_RD, 16'h0000});
    check({phy_u.op, 30'(phy_u.frames - n)}, {MDIO_OP_RD, 30'h1});
    check({30'h0, mdc, mdio_oe}, 32'h0000_0000);
    // links, polarity and forwarding gates
    ahb(1'b0, REG_LINK, 32'h0, rd);
    check(rd, 32'h0000_000F);
    fwd(0, 7, 1'b1);
    fwd(3, 4, 1'b1);
    phy_u.set_link(2, 1'b0);
    fwd(1, 3, 1'b0);
    ahb(1'b1, REG_CTRL, 32'h0000_0003, rd);
    ahb(1'b0, REG_LINK, 32'h0, rd);
    check(rd, 32'h0000_0004);
    phy_u.set_link(2, 1'b1);
    fwd(0, 2, 1'b0);
    ahb(1'b1, REG_CTRL, 32'h0000_0000, rd);
    fwd(0, 2, 1'b0);
    // sticky receive error, cleared by writing one
    phy_u.send(2, 3, 4'h0, 1);
    ahb(1'b0, REG_RXERR, 32'h0, rd);
    check(rd, 32'h0000_0004);
    ahb(1'b1, REG_RXERR, 32'h0000_0004, rd);
    ahb(1'b0, REG_RXERR, 32'h0, rd);
    check(rd, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
